// ===== rtl/bkreg_defs.vh
// constants for the regulator control register block
`ifndef BKREG_DEFS_VH
`define BKREG_DEFS_VH
`define BKREG_ADDR_TGT_A 8'h01
`define BKREG_ADDR_TGT_B 8'h02
`define BKREG_ADDR_CTRL 8'h03
`define BKREG_ADDR_FLAGS 8'h05
`define BKREG_RST_TGT 8'h64
`define BKREG_RST_CTRL 8'h6F
`define BKREG_BIT_SWRST 7
`define BKREG_BIT_FORCED_FIXED_FREQUENCY_CHG 6
`define BKREG_BIT_DEV_EN 5
`define BKREG_BIT_LL_PWM 4
`define BKREG_BIT_DISCHG 3
`define BKREG_BIT_HICCUP 2
`define BKREG_FLAG_TWARN 4
`define BKREG_FLAG_HICCUP 3
`define BKREG_FLAG_INPUT_LOW_FLAG 0
`define BKREG_CLK_MHZ 25
// step times in ns, enable delay and waits in us
`define BKREG_STEP_NS_0 250
`define BKREG_STEP_NS_1 500
`define BKREG_STEP_NS_2 1000
`define BKREG_STEP_NS_3 5000
`define BKREG_EN_DELAY_US 640
// enable delay already in clock cycles, sized for the 16-bit delay timer
`define BKREG_EN_DELAY_CYC 16'h3E80
`define BKREG_PG_WAIT_US 200
`define BKREG_HICCUP_OFF_US 128
`define BKREG_TRIP_LIMIT 7'h40
`endif

// ===== rtl/bkreg_ramp.v
// target ramp stepper: moves the output code one step per interval
`timescale 1ns/1ps
`include "bkreg_defs.vh"
module bkreg_ramp (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire clear_in,
   input wire [7:0] load_code_in,
   input wire [7:0] goal_in,
   input wire [1:0] speed_in,
   output reg [7:0] code_out,
   output reg busy_out
);
   localparam integer STEP0_FULL = (`BKREG_STEP_NS_0 * `BKREG_CLK_MHZ) / 1000;
   localparam integer STEP1_FULL = (`BKREG_STEP_NS_1 * `BKREG_CLK_MHZ) / 1000;
   localparam integer STEP2_FULL = (`BKREG_STEP_NS_2 * `BKREG_CLK_MHZ) / 1000;
   localparam integer STEP3_FULL = (`BKREG_STEP_NS_3 * `BKREG_CLK_MHZ) / 1000;
   localparam [15:0] STEP0 = STEP0_FULL[15:0];
   localparam [15:0] STEP1 = STEP1_FULL[15:0];
   localparam [15:0] STEP2 = STEP2_FULL[15:0];
   localparam [15:0] STEP3 = STEP3_FULL[15:0];
   reg [15:0] cnt_q;
   reg [15:0] period;
   always @* begin
      case (speed_in)
         2'b00: period = STEP0;
         2'b01: period = STEP1;
         2'b10: period = STEP2;
         default: period = STEP3;
      endcase
   end
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         code_out <= 8'h00;
         busy_out <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (clear_in) begin
         code_out <= load_code_in;
         busy_out <= 1'b0;
         cnt_q <= 16'h0000;
      end else if (code_out != goal_in) begin
         busy_out <= 1'b1;
         if (cnt_q + 16'h0001 >= period) begin
            cnt_q <= 16'h0000;
            code_out <= (goal_in > code_out) ? code_out + 8'h01 : code_out - 8'h01;
         end else begin
            cnt_q <= cnt_q + 16'h0001;
         end
      end else begin
         busy_out <= 1'b0;
         cnt_q <= 16'h0000;
      end
   end
endmodule

// ===== rtl/bkreg_top.v
// register and sequencing logic of the step-down regulator control block
// Function
// - bias the setpoint resistor during enable delay, stop bias after conversion
// - on host target write, reach resistor start-up voltage first, then ramp
// - select pin low uses target a, high uses target b
// - register writes and select toggles are ramped at the configured speed
// - ramp speed 00/01/10/11 gives 0.24/0.48/1/5 us per step
// - power-good compare after enable delay; 200 us after 91 percent, pin high
// - power-good high inside 91..111 percent, low outside or in thermal shutdown
// - on power-good variant only target a governs the output
// - all registers are 8 bits, bit 0 least significant
// - targets are 400 mV plus 5 mV per code, reset to 0x64
// - writing 1 to control bit 7 returns all registers to defaults
// - control bit 6 forces fixed-frequency mode during voltage changes
// - clearing control bit 5 stops switching; setting restarts without enable delay
// - control bit 4 chooses fixed-frequency at light load, else skip mode
// - control bit 3 enables the output discharge path
// - control bit 2 selects hiccup retry, else latching short protection
// - status bit 4 reports junction temperature warning
// - status bit 3 set once a hiccup event happened
// - status bit 0 set when input is under lockout threshold
// - enable low resets registers except discharge bit; enable rise resets it too
// - 64 current-limit trips, counted without clearing between them, start a 128 us switching-off hiccup
`timescale 1ns/1ps
`include "bkreg_defs.vh"
module bkreg_top #(
   parameter PG_VARIANT = 0,
   parameter [15:0] EN_DELAY_CYC = `BKREG_EN_DELAY_CYC
) (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire enable_pin_in,
   input wire target_select_pin_in,
   input wire digitizer_done_in,
   input wire [7:0] digitizer_code_in,
   input wire vout_above_low_in,
   input wire vout_above_high_in,
   input wire thermal_warn_in,
   input wire thermal_shutdown_in,
   input wire input_low_in,
   input wire current_trip_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   output reg bias_on_out,
   output reg digitize_start_out,
   output reg [7:0] dac_code_out,
   output reg switching_en_out,
   output reg soft_start_out,
   output reg forced_fixed_frequency_out,
   output reg discharge_on_out,
   output reg latch_protect_out,
   output reg power_good_low_pin_out
);
   localparam integer PG_WAIT_FULL = `BKREG_PG_WAIT_US * `BKREG_CLK_MHZ;
   localparam integer HICCUP_FULL = `BKREG_HICCUP_OFF_US * `BKREG_CLK_MHZ;
   localparam [15:0] PG_WAIT_CYC = PG_WAIT_FULL[15:0];
   localparam [15:0] HICCUP_CYC = HICCUP_FULL[15:0];
   localparam [2:0] S_OFF = 3'h0;
   localparam [2:0] S_DELAY = 3'h1;
   localparam [2:0] S_START = 3'h2;
   localparam [2:0] S_RUN = 3'h3;
   localparam [2:0] S_HICCUP = 3'h4;
   localparam [2:0] S_LATCH = 3'h5;
   localparam [2:0] S_SWOFF = 3'h6;

   // pin and analog inputs come from outside the clock domain
   reg [8:0] sync1_q;
   reg [8:0] sync2_q;
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync1_q <= 9'h000;
         sync2_q <= 9'h000;
      end else begin
         sync1_q <= {enable_pin_in, target_select_pin_in, digitizer_done_in, vout_above_low_in,
            vout_above_high_in, thermal_warn_in, thermal_shutdown_in, input_low_in, current_trip_in};
         sync2_q <= sync1_q;
      end
   end
   wire en_s = sync2_q[8];
   wire sel_s = sync2_q[7];
   wire dig_done_s = sync2_q[6];
   wire above_lo_s = sync2_q[5];
   wire above_hi_s = sync2_q[4];
   wire twarn_s = sync2_q[3];
   wire tsd_s = sync2_q[2];
   wire input_low_flag_s = sync2_q[1];
   wire trip_s = sync2_q[0];

   reg en_prev_q;
   reg trip_prev_q;
   reg [7:0] tgt_a_q;
   reg [7:0] tgt_b_q;
   reg [7:0] ctrl_q;
   reg [7:0] startup_code_q;
   reg hiccup_flag_q;
   reg startup_reached_q;
   reg [2:0] state_q;
   reg [15:0] timer_q;
   reg [6:0] trip_cnt_q;
   reg [15:0] pg_cnt_q;
   reg [7:0] goal;
   reg [7:0] flags;
   wire en_rise = en_s && !en_prev_q;
   wire ctrl_wr = reg_wr_in && (reg_addr_in == `BKREG_ADDR_CTRL);
   wire sw_reset = ctrl_wr && reg_wdata_in[`BKREG_BIT_SWRST];
   wire ramp_clear = (state_q == S_OFF) || (state_q == S_DELAY) || (state_q == S_SWOFF);
   wire [7:0] ramp_code;
   wire ramp_busy;

   // active target: select pin unless the power-good variant pins it to a
   always @* begin
      if (PG_VARIANT != 0 || !sel_s) begin
         goal = tgt_a_q;
      end else begin
         goal = tgt_b_q;
      end
      // hold the resistor start-up code until it has been reached once
      if (!startup_reached_q) begin
         goal = startup_code_q;
      end
   end

   bkreg_ramp u_ramp (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .clear_in(ramp_clear),
      .load_code_in(8'h00),
      .goal_in(goal),
      .speed_in(ctrl_q[1:0]),
      .code_out(ramp_code),
      .busy_out(ramp_busy)
   );

   // registers; enable low clears all but the discharge bit
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tgt_a_q <= `BKREG_RST_TGT;
         tgt_b_q <= `BKREG_RST_TGT;
         ctrl_q <= `BKREG_RST_CTRL;
         hiccup_flag_q <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         en_prev_q <= en_s;
         if (!en_s || sw_reset || input_low_flag_s) begin
            tgt_a_q <= `BKREG_RST_TGT;
            tgt_b_q <= `BKREG_RST_TGT;
            ctrl_q <= (`BKREG_RST_CTRL & 8'hF7) | (ctrl_q & 8'h08);
            hiccup_flag_q <= 1'b0;
            if (sw_reset) begin
               ctrl_q <= `BKREG_RST_CTRL;
            end
         end else begin
            if (en_rise) begin
               ctrl_q[`BKREG_BIT_DISCHG] <= 1'b1;
            end
            if (reg_wr_in && reg_addr_in == `BKREG_ADDR_TGT_A) begin
               tgt_a_q <= reg_wdata_in;
            end
            if (reg_wr_in && reg_addr_in == `BKREG_ADDR_TGT_B) begin
               tgt_b_q <= reg_wdata_in;
            end
            if (ctrl_wr) begin
               ctrl_q <= {1'b0, reg_wdata_in[6:0]};
            end
            if (state_q == S_HICCUP) begin
               hiccup_flag_q <= 1'b1;
            end
         end
      end
   end

   // status: reserved bits zero, writes have no effect
   always @* begin
      flags = 8'h00;
      flags[`BKREG_FLAG_TWARN] = twarn_s;
      flags[`BKREG_FLAG_HICCUP] = hiccup_flag_q;
      flags[`BKREG_FLAG_INPUT_LOW_FLAG] = input_low_flag_s;
   end

   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `BKREG_ADDR_TGT_A: reg_rdata_out <= tgt_a_q;
            `BKREG_ADDR_TGT_B: reg_rdata_out <= tgt_b_q;
            `BKREG_ADDR_CTRL: reg_rdata_out <= ctrl_q;
            `BKREG_ADDR_FLAGS: reg_rdata_out <= flags;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // start-up sequencer
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_q <= S_OFF;
         timer_q <= 16'h0000;
         trip_cnt_q <= 7'h00;
         trip_prev_q <= 1'b0;
         startup_code_q <= `BKREG_RST_TGT;
         startup_reached_q <= 1'b0;
         bias_on_out <= 1'b0;
         digitize_start_out <= 1'b0;
      end else begin
         trip_prev_q <= trip_s;
         digitize_start_out <= 1'b0;
         if (!en_s || input_low_flag_s) begin
            state_q <= S_OFF;
            bias_on_out <= 1'b0;
            startup_reached_q <= 1'b0;
         end else begin
            case (state_q)
               S_OFF: begin
                  state_q <= S_DELAY;
                  timer_q <= 16'h0000;
                  bias_on_out <= 1'b1;
                  digitize_start_out <= 1'b1;
               end
               S_DELAY: begin
                  timer_q <= timer_q + 16'h0001;
                  if (bias_on_out && dig_done_s) begin
                     bias_on_out <= 1'b0;
                     startup_code_q <= digitizer_code_in;
                  end
                  if (timer_q + 16'h0001 >= EN_DELAY_CYC) begin
                     state_q <= S_START;
                  end
               end
               S_START, S_RUN: begin
                  if (!ctrl_q[`BKREG_BIT_DEV_EN]) begin
                     state_q <= S_SWOFF;
                  end else if (tsd_s) begin
                     state_q <= S_START;
                  end else begin
                     if (ramp_code == startup_code_q) begin
                        startup_reached_q <= 1'b1;
                     end
                     if (startup_reached_q) begin
                        state_q <= S_RUN;
                     end
                     if (trip_s && !trip_prev_q) begin
                        trip_cnt_q <= trip_cnt_q + 7'h01;
                     end else if (!trip_s && trip_prev_q && 1'b0) begin
                        trip_cnt_q <= 7'h00;
                     end
                     if (trip_cnt_q >= `BKREG_TRIP_LIMIT) begin
                        trip_cnt_q <= 7'h00;
                        timer_q <= 16'h0000;
                        state_q <= ctrl_q[`BKREG_BIT_HICCUP] ? S_HICCUP : S_LATCH;
                     end
                  end
               end
               S_HICCUP: begin
                  timer_q <= timer_q + 16'h0001;
                  startup_reached_q <= 1'b0;
                  if (timer_q + 16'h0001 >= HICCUP_CYC) begin
                     state_q <= S_SWOFF;
                  end
               end
               S_LATCH: begin
                  state_q <= S_LATCH;
               end
               S_SWOFF: begin
                  startup_reached_q <= 1'b0;
                  if (ctrl_q[`BKREG_BIT_DEV_EN]) begin
                     state_q <= S_START;
                  end
               end
               default: state_q <= S_OFF;
            endcase
         end
      end
   end

   wire running = (state_q == S_START) || (state_q == S_RUN);

   // outputs and power-good window
   always @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dac_code_out <= 8'h00;
         switching_en_out <= 1'b0;
         soft_start_out <= 1'b0;
         forced_fixed_frequency_out <= 1'b0;
         discharge_on_out <= 1'b0;
         latch_protect_out <= 1'b0;
         power_good_low_pin_out <= 1'b0;
         pg_cnt_q <= 16'h0000;
      end else begin
         dac_code_out <= ramp_code;
         switching_en_out <= running && !tsd_s;
         soft_start_out <= (state_q == S_START);
         forced_fixed_frequency_out <= ctrl_q[`BKREG_BIT_LL_PWM] ||
            (ctrl_q[`BKREG_BIT_FORCED_FIXED_FREQUENCY_CHG] && ramp_busy);
         discharge_on_out <= ctrl_q[`BKREG_BIT_DISCHG] && (!running || tsd_s);
         latch_protect_out <= (state_q == S_LATCH) || !ctrl_q[`BKREG_BIT_HICCUP];
         if (PG_VARIANT == 0 || !running || tsd_s || !above_lo_s || above_hi_s) begin
            pg_cnt_q <= 16'h0000;
            power_good_low_pin_out <= 1'b0;
         end else if (pg_cnt_q + 16'h0001 >= PG_WAIT_CYC) begin
            power_good_low_pin_out <= 1'b1;
         end else begin
            pg_cnt_q <= pg_cnt_q + 16'h0001;
         end
      end
   end
endmodule

// ===== sim/bkreg_props.sv
// port-level properties of the regulator control register block
`timescale 1ns/1ps
module bkreg_props #(
   parameter [15:0] EN_DELAY_CYC = 16'h3E80
) (
   input wire ref_clk_in,
   input wire resetn_in,
   input wire enable_pin_in,
   input wire digitizer_done_in,
   input wire thermal_warn_in,
   input wire input_low_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire bias_on_out,
   input wire digitize_start_out,
   input wire [7:0] dac_code_out,
   input wire switching_en_out
);
   // writes are only judged once the enable delay and the pin sync are surely over
   reg [15:0] up_q;
   wire live = (up_q > EN_DELAY_CYC + 16'h0004) && enable_pin_in && !input_low_in;
   wire mapped = reg_addr_in == 8'h01 || reg_addr_in == 8'h02 || reg_addr_in == 8'h03 || reg_addr_in == 8'h05;
   wire run = switching_en_out;
   always @(posedge ref_clk_in or negedge resetn_in)
      if (!resetn_in)
         up_q <= 16'h0000;
      else if (!enable_pin_in || input_low_in)
         up_q <= 16'h0000;
      else if (up_q <= EN_DELAY_CYC + 16'h0004)
         up_q <= up_q + 16'h0001;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   a_unmapped_reads_zero: assert property (reg_rd_in && !mapped |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_reserved_flags_zero: assert property (reg_rd_in && reg_addr_in == 8'h05 |=> (reg_rdata_out & 8'hE6) == 8'h00)
      else $error("reserved status bits set");
   a_ramp_single_step: assert property (run && $past(run) && $changed(dac_code_out) |->
      (dac_code_out - $past(dac_code_out) == 8'h01 || $past(dac_code_out) - dac_code_out == 8'h01))
      else $error("ramp moved more than one code");
   a_ramp_step_spacing: assert property (run && $past(run) && $changed(dac_code_out) |=> $stable(dac_code_out)[*5])
      else $error("ramp stepped faster than six cycles");
   a_bias_off_done: assert property (digitizer_done_in[*4] |-> !bias_on_out)
      else $error("bias still on after conversion");
   a_start_one_pulse: assert property (digitize_start_out |=> !digitize_start_out)
      else $error("conversion start longer than one cycle");
   a_disabled_stays_idle: assert property (!enable_pin_in[*5] |-> !switching_en_out && !bias_on_out)
      else $error("active while enable pin low");
   a_target_write_read: assert property (live && reg_wr_in && reg_addr_in == 8'h01 ##2
      reg_rd_in && reg_addr_in == 8'h01 |=> reg_rdata_out == $past(reg_wdata_in, 3))
      else $error("target readback differs from write");
   a_soft_reset_ctrl: assert property (live && reg_wr_in && reg_addr_in == 8'h03 && reg_wdata_in[7] ##2
      reg_rd_in && reg_addr_in == 8'h03 |=> reg_rdata_out == 8'h6F)
      else $error("control not default after software reset");
   a_warn_flag_live: assert property (thermal_warn_in[*4] ##0 reg_rd_in && reg_addr_in == 8'h05 |=> reg_rdata_out[4])
      else $error("thermal warning flag missing");
   c_ramp_step: cover property (run && $changed(dac_code_out));
   c_conversion: cover property (digitize_start_out);
   c_flags_read: cover property (reg_rd_in && reg_addr_in == 8'h05);
endmodule
bind bkreg_top bkreg_props #(.EN_DELAY_CYC(EN_DELAY_CYC)) u_props (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
   .enable_pin_in(enable_pin_in), .digitizer_done_in(digitizer_done_in), .thermal_warn_in(thermal_warn_in),
   .input_low_in(input_low_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .bias_on_out(bias_on_out),
   .digitize_start_out(digitize_start_out), .dac_code_out(dac_code_out), .switching_en_out(switching_en_out));

// ===== sim/bkreg_host.sv
// host model: register strobe master, prompt or paced by GAP idle cycles
`timescale 1ns/1ps
module bkreg_host #(
   parameter GAP = 0,
   parameter WAIT_CYC = 54
) (
   input wire ref_clk_in,
   input wire [7:0] rdata_in,
   output reg wr_out,
   output reg rd_out,
   output reg [7:0] addr_out,
   output reg [7:0] wdata_out
);
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   task wait_ready;
      repeat (WAIT_CYC) @(posedge ref_clk_in);
   endtask
   task wr(input [7:0] a, input [7:0] d);
      begin
         repeat (GAP + 1) @(posedge ref_clk_in);
         wr_out <= 1'b1;
         addr_out <= a;
         wdata_out <= d;
         @(posedge ref_clk_in);
         wr_out <= 1'b0;
         // stale data is inverted so nothing can lean on it
         wdata_out <= ~d;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         repeat (GAP + 1) @(posedge ref_clk_in);
         rd_out <= 1'b1;
         addr_out <= a;
         @(posedge ref_clk_in);
         rd_out <= 1'b0;
         @(posedge ref_clk_in);
         d = rdata_in;
      end
   endtask
endmodule

// ===== sim/test_buck_regulator_control_regs.sv
// self-checking bench for the regulator control register block
`timescale 1ns/1ps
module test_buck_regulator_control_regs;
   localparam [15:0] DLY = 16'h0032;
   localparam [39:0] ADRS = 40'h0102030405;
   localparam [39:0] EXPS = 40'h64646F0000;
   localparam [31:0] STEPS = {8'd125, 8'd25, 8'd12, 8'd6};
   reg ref_clk_in = 1'b0;
   reg resetn_in = 1'b0;
   reg en = 1'b0, sel = 1'b0, done = 1'b0, twarn = 1'b0, ulow = 1'b0, trip = 1'b0;
   reg vlo = 1'b0, vhi = 1'b0, tsd = 1'b0;
   reg [7:0] dcode = 8'h18;
   reg [7:0] v, mx;
   wire wr, rd, bias, dstart, sw, ffm, dis, latch, ss, pg;
   wire [7:0] addr, wdata, rdata, dac, pg_dac;
   integer n_fail = 0, checked = 0, cyc = 0, i, s, cnt;
   always #20 ref_clk_in = ~ref_clk_in;
   bkreg_host #(.GAP(0), .WAIT_CYC(DLY + 16'h0004)) host (.ref_clk_in(ref_clk_in), .rdata_in(rdata), .wr_out(wr),
      .rd_out(rd), .addr_out(addr), .wdata_out(wdata));
   bkreg_top #(.PG_VARIANT(0), .EN_DELAY_CYC(DLY)) uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .enable_pin_in(en), .target_select_pin_in(sel), .digitizer_done_in(done), .digitizer_code_in(dcode),
      .vout_above_low_in(vlo), .vout_above_high_in(vhi), .thermal_warn_in(twarn), .thermal_shutdown_in(tsd),
      .input_low_in(ulow), .current_trip_in(trip), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .bias_on_out(bias), .digitize_start_out(dstart),
      .dac_code_out(dac), .switching_en_out(sw), .soft_start_out(ss), .forced_fixed_frequency_out(ffm),
      .discharge_on_out(dis), .latch_protect_out(latch), .power_good_low_pin_out());
   // power-good variant on the same pins and bus: select pin must not move its output
   bkreg_top #(.PG_VARIANT(1), .EN_DELAY_CYC(DLY)) uut_pg (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .enable_pin_in(en), .target_select_pin_in(sel), .digitizer_done_in(done), .digitizer_code_in(dcode),
      .vout_above_low_in(vlo), .vout_above_high_in(vhi), .thermal_warn_in(twarn), .thermal_shutdown_in(tsd),
      .input_low_in(ulow), .current_trip_in(trip), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(), .bias_on_out(), .digitize_start_out(),
      .dac_code_out(pg_dac), .switching_en_out(), .soft_start_out(), .forced_fixed_frequency_out(),
      .discharge_on_out(), .latch_protect_out(), .power_good_low_pin_out(pg));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d, mismatches %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   task idle(input integer n);
      repeat (n) @(negedge ref_clk_in);
   endtask
   task power_up;
      begin
         @(posedge ref_clk_in);
         en <= 1'b1;
         for (i = 0; i < 20 && dstart !== 1'b1; i = i + 1)
            @(negedge ref_clk_in);
         idle(1);
         chk({7'h00, bias}, 8'h01);
         @(posedge ref_clk_in);
         done <= 1'b1;
         idle(6);
         chk({7'h00, bias}, 8'h00);
         host.wait_ready;
      end
   endtask
   task wait_dac(input [7:0] goal);
      begin
         mx = dac;
         for (i = 0; i < 4000 && dac !== goal; i = i + 1) begin
            @(negedge ref_clk_in);
            if (dac > mx)
               mx = dac;
         end
      end
   endtask
   // the first step after a goal change may come early, so the second interval is timed
   task step_gap;
      begin
         v = dac;
         for (i = 0; i < 300 && dac === v; i = i + 1)
            @(negedge ref_clk_in);
         v = dac;
         for (cnt = 0; cnt < 300 && dac === v; cnt = cnt + 1)
            @(negedge ref_clk_in);
      end
   endtask
   task wr_ctrl(input [7:0] d);
      begin
         host.wr(8'h03, d);
         idle(3);
      end
   endtask
   always @(posedge ref_clk_in) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         n_fail = n_fail + 1;
         wrap_up;
      end
   end
   initial begin
      repeat (5) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      power_up;
      for (s = 0; s < 5; s = s + 1) begin
         host.rd(ADRS[8*s +: 8], v);
         chk(v, EXPS[8*s +: 8]);
      end
      host.wr(8'h05, 8'hFF);
      host.rd(8'h05, v);
      chk(v, 8'h00);
      host.wr(8'h03, 8'h6C);
      host.wr(8'h01, 8'h08);
      host.rd(8'h01, v);
      chk(v, 8'h08);
      host.wr(8'h02, 8'h10);
      // the ramp passes the target on its climb to the start-up code
      wait_dac(8'h18);
      wait_dac(8'h08);
      chk(mx, 8'h18);
      chk(dac, 8'h08);
      for (s = 0; s < 4; s = s + 1) begin
         host.wr(8'h03, 8'h6C | s[7:0]);
         @(posedge ref_clk_in);
         sel <= ~sel;
         step_gap;
         chk(cnt[7:0], STEPS[8*s +: 8]);
         chk({7'h00, ffm}, 8'h01);
         wait_dac(sel ? 8'h10 : 8'h08);
         chk(dac, sel ? 8'h10 : 8'h08);
         chk(pg_dac, 8'h08);
      end
      @(posedge ref_clk_in);
      vlo <= 1'b1;
      idle(4990);
      chk({7'h00, pg}, 8'h00);
      idle(20);
      chk({7'h00, pg}, 8'h01);
      @(posedge ref_clk_in);
      vhi <= 1'b1;
      idle(4);
      chk({7'h00, pg}, 8'h00);
      idle(3);
      chk({7'h00, ffm}, 8'h00);
      wr_ctrl(8'h7C);
      chk({7'h00, ffm}, 8'h01);
      wr_ctrl(8'h68);
      chk({7'h00, latch}, 8'h01);
      wr_ctrl(8'h4C);
      chk({6'h00, sw, dis}, 8'h01);
      wr_ctrl(8'h44);
      chk({7'h00, dis}, 8'h00);
      host.rd(8'h01, v);
      chk(v, 8'h08);
      wr_ctrl(8'h6C);
      chk({6'h00, ss, sw}, 8'h03);
      for (s = 0; s < 64; s = s + 1) begin
         if (s == 63) begin
            host.rd(8'h05, v);
            chk(v, 8'h00);
         end
         @(posedge ref_clk_in);
         trip <= 1'b1;
         repeat (2) @(posedge ref_clk_in);
         trip <= 1'b0;
         repeat (2) @(posedge ref_clk_in);
      end
      idle(8);
      chk({7'h00, sw}, 8'h00);
      host.rd(8'h05, v);
      chk(v, 8'h08);
      idle(3100);
      chk({7'h00, sw}, 8'h00);
      idle(200);
      chk({7'h00, sw}, 8'h01);
      @(posedge ref_clk_in);
      twarn <= 1'b1;
      idle(3);
      host.rd(8'h05, v);
      chk(v, 8'h18);
      host.wr(8'h03, 8'h80);
      host.rd(8'h03, v);
      chk(v, 8'h6F);
      host.rd(8'h01, v);
      chk(v, 8'h64);
      @(posedge ref_clk_in);
      ulow <= 1'b1;
      // lockout restarts the conversion, so the digitizer drops its done level
      done <= 1'b0;
      idle(3);
      host.rd(8'h05, v);
      chk(v & 8'h01, 8'h01);
      @(posedge ref_clk_in);
      ulow <= 1'b0;
      twarn <= 1'b0;
      idle(4);
      @(posedge ref_clk_in);
      done <= 1'b1;
      host.wr(8'h01, 8'h30);
      host.wr(8'h03, 8'h64);
      @(posedge ref_clk_in);
      en <= 1'b0;
      done <= 1'b0;
      repeat (10) @(posedge ref_clk_in);
      power_up;
      host.rd(8'h01, v);
      chk(v, 8'h64);
      host.rd(8'h03, v);
      chk(v, 8'h6F);
      wrap_up;
   end
endmodule
